// File: cal_pkg.sv
`default_nettype none
package cal_pkg;
  localparam int SAMPLE_W = 12;
  localparam int NUM_CORES = 3;
  localparam int NUM_BANKS = 6;
  localparam logic [SAMPLE_W-1:0] MID_CODE = 12'h000;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TRIM_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_TRIM_GAIN = 8'h0c;
  localparam logic [7:0] ADDR_TRIM_TIMING = 8'h10;
  localparam logic [7:0] ADDR_TRIM_TERM = 8'h14;
  localparam int CTRL_W = 7;
  localparam int STAT_W = 15;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one calibration step per bank and per quantity
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_TIME_NS = 800;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;

  typedef logic [1:0] core_id_t;
  localparam core_id_t CORE_A = 2'h0;
  localparam core_id_t CORE_B = 2'h1;
  localparam core_id_t CORE_C = 2'h2;

  typedef enum logic [2:0] {
    S_FG = 3'b001,
    S_IDLE = 3'b010,
    S_BG = 3'b100
  } mode_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LIN = 5'b00010,
    ST_GAIN = 5'b00100,
    ST_OFFS = 5'b01000,
    ST_BUFOS = 5'b10000
  } cal_step_t;

  // ctrl register, bit 0 at the bottom
  typedef struct packed {
    logic single_in_b;
    logic single_ch;
    logic background_offset_cal;
    logic foreground_offset_cal;
    logic background_cal_enable;
    logic cal_software_trigger;
    logic cal_trigger_source_select;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = 7'h00;

  typedef struct packed {
    core_id_t slot_b;
    core_id_t slot_a;
    core_id_t spare;
  } core_map_t;
  localparam core_map_t MAP_RESET = '{slot_b: CORE_B, slot_a: CORE_A, spare: CORE_C};

  typedef struct packed {
    cal_step_t step;
    logic eng_busy;
    core_map_t map;
    logic bg_active;
    logic fg_done;
    logic fg_busy;
  } status_t;

  typedef struct packed {
    logic [15:0] term;
    logic [15:0] timing;
    logic [15:0] gain;
    logic [15:0] offset;
  } trim_t;
  // factory defaults, values arbitrary
  localparam trim_t TRIM_DEFAULT = '{term: 16'h0010, timing: 16'h0040, gain: 16'h0080, offset: 16'h0800};
endpackage
`default_nettype wire

// File: bank_cal_engine.sv
`default_nettype none
module bank_cal_engine import cal_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire core_id_t core,
  input wire logic buf_offset,
  // progress
  output logic busy,
  output logic done,
  output cal_step_t step,
  output logic bank,
  output core_id_t cal_core,
  output logic ref_en
);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

  cal_step_t step_q;
  logic [CNT_W-1:0] cnt_q;
  logic bank_q;
  logic done_q;
  logic bufos_q;
  core_id_t core_q;
  logic step_end;

  assign step_end = (step_q != ST_IDLE) && (cnt_q == STEP_LAST);
  assign busy = (step_q != ST_IDLE);
  assign done = done_q;
  assign step = step_q;
  assign bank = bank_q;
  assign cal_core = core_q;
  // reference generator runs for the whole pass
  assign ref_en = busy;

  always_ff @(posedge clk)
  begin
    if (!rst_n || step_q == ST_IDLE || step_end)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      step_q <= ST_IDLE;
      bank_q <= 1'b0;
      done_q <= 1'b0;
      bufos_q <= 1'b0;
      core_q <= CORE_A;
    end
    else
    begin
      done_q <= 1'b0;
      if (step_q == ST_IDLE)
      begin
        if (start)
        begin
          step_q <= ST_LIN;
          bank_q <= 1'b0;
          bufos_q <= buf_offset;
          core_q <= core;
        end
      end
      else if (step_end)
      begin
        case (step_q)
          ST_LIN: step_q <= ST_GAIN;
          ST_GAIN: step_q <= ST_OFFS;
          ST_OFFS,
          ST_BUFOS:
          begin
            if (step_q == ST_OFFS && bufos_q)
              step_q <= ST_BUFOS;
            else if (!bank_q)
            begin
              bank_q <= 1'b1;
              step_q <= ST_LIN;
            end
            else
            begin
              step_q <= ST_IDLE;
              done_q <= 1'b1;
            end
          end
          default: step_q <= ST_IDLE;
        endcase
      end
    end
  end

  AST_STEP_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(step_q == ST_GAIN) |-> $past(step_q) == ST_LIN && $past(cnt_q) == STEP_LAST)
    else $error("gain step not preceded by a full linearity step");
  AST_PASS_LENGTH: assert property (@(posedge clk) disable iff (!rst_n)
    (step_q == ST_IDLE && start) |=> (step_q == ST_LIN)[*8] ##1 (step_q == ST_LIN)[*8] ##1 step_q == ST_GAIN)
    else $error("linearity step length wrong");
endmodule // bank_cal_engine
`default_nettype wire

// File: core_cal_ctrl.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module core_cal_ctrl import cal_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger pin
  input wire logic cal_pin_trigger,
  // sample path
  input wire logic [NUM_BANKS-1:0][SAMPLE_W-1:0] bank_sample,
  output logic [SAMPLE_W-1:0] sample_a,
  output logic [SAMPLE_W-1:0] sample_b,
  // converter control
  output logic [NUM_CORES-1:0] core_online,
  output logic [NUM_CORES-1:0] core_on_input_b,
  output core_id_t cal_core,
  output logic cal_bank,
  output cal_step_t cal_step,
  output logic cal_ref_en,
  output trim_t trim,
  output logic cal_in_progress
);
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_TRIM_OFFSET) ||
      (a == ADDR_TRIM_GAIN) || (a == ADDR_TRIM_TIMING) || (a == ADDR_TRIM_TERM);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [SAMPLE_W-1:0] core_sample(input logic [NUM_BANKS-1:0][SAMPLE_W-1:0] b,
    input core_id_t c, input logic ph);
    core_sample = b[{c, ph}];
  endfunction

  mode_t state_q;
  ctrl_t ctrl_q;
  trim_t trim_q;
  core_map_t map_q;
  core_id_t fg_core_q;
  logic start_q, fg_done_q, next_b_q, soft_prev_q, phase_q;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [SAMPLE_W-1:0] sample_a_q, sample_b_q;
  logic [NUM_CORES-1:0] online_q, in_b_q;
  logic eng_busy, eng_done, wr_fire, bg_run, trig, pin_rise, soft_rise;
  status_t stat;

  // clear wins only on the edge that starts a new foreground pass
  assign pin_rise = pin_s2_q & ~pin_s3_q;
  assign soft_rise = ctrl_q.cal_software_trigger & ~soft_prev_q;
  assign trig = ctrl_q.cal_trigger_source_select ? pin_rise : soft_rise;
  // background only under software source with trigger held
  assign bg_run = ctrl_q.background_cal_enable & ~ctrl_q.cal_trigger_source_select &
    ctrl_q.cal_software_trigger;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      soft_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= cal_pin_trigger;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      soft_prev_q <= ctrl_q.cal_software_trigger;
    end
  end

  bank_cal_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_q),
    .core(state_q == S_FG ? fg_core_q : map_q.spare),
    .buf_offset(state_q == S_FG ? ctrl_q.foreground_offset_cal : ctrl_q.background_offset_cal),
    .busy(eng_busy),
    .done(eng_done),
    .step(cal_step),
    .bank(cal_bank),
    .cal_core(cal_core),
    .ref_en(cal_ref_en)
  );

  // reset lands in foreground with a start pending
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= S_FG;
      fg_core_q <= CORE_A;
      start_q <= 1'b1;
      fg_done_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      case (state_q)
        S_FG:
        begin
          if (eng_done && fg_core_q == CORE_C)
          begin
            state_q <= S_IDLE;
            fg_done_q <= 1'b1;
          end
          else if (eng_done)
          begin
            fg_core_q <= fg_core_q + 2'h1;
            start_q <= 1'b1;
          end
        end
        S_IDLE:
        begin
          if (bg_run)
          begin
            state_q <= S_BG;
            start_q <= 1'b1;
          end
          else if (trig)
          begin
            state_q <= S_FG;
            fg_core_q <= CORE_A;
            start_q <= 1'b1;
            fg_done_q <= 1'b0;
          end
        end
        S_BG:
        begin
          if (eng_done && bg_run)
            start_q <= 1'b1;
          else if (eng_done)
            state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // calibrated spare takes a slot, alternating A then B
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      map_q <= MAP_RESET;
      next_b_q <= 1'b0;
    end
    else if (state_q == S_BG && eng_done)
    begin
      next_b_q <= ~next_b_q;
      if (next_b_q)
      begin
        map_q.slot_b <= map_q.spare;
        map_q.spare <= map_q.slot_b;
      end
      else
      begin
        map_q.slot_a <= map_q.spare;
        map_q.spare <= map_q.slot_a;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      phase_q <= 1'b0;
    else
      phase_q <= ~phase_q;
  end

  // swap is a single mux change, so the stream never skips a sample
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sample_a_q <= MID_CODE;
      sample_b_q <= MID_CODE;
      online_q <= '0;
    end
    else if (state_q == S_FG)
    begin
      sample_a_q <= MID_CODE;
      sample_b_q <= MID_CODE;
      online_q <= '0;
    end
    else
    begin
      sample_a_q <= core_sample(bank_sample, map_q.slot_a, phase_q);
      sample_b_q <= core_sample(bank_sample, map_q.slot_b, phase_q);
      online_q <= NUM_CORES'((3'h1 << map_q.slot_a) | (3'h1 << map_q.slot_b));
    end
  end

  for (genvar i = 0; i < NUM_CORES; i++)
  begin : g_core
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        in_b_q[i] <= 1'b0;
      else if (map_q.slot_b == 2'(i))
        in_b_q[i] <= ctrl_q.single_ch ? ctrl_q.single_in_b : 1'b1;
      else if (map_q.slot_a == 2'(i))
        in_b_q[i] <= ctrl_q.single_ch & ctrl_q.single_in_b;
      else
        in_b_q[i] <= 1'b0;
    end
  end

  // write channel: address and data taken in either order
  assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RESET;
      trim_q <= TRIM_DEFAULT;
    end
    else if (wr_fire)
    begin
      if (aw_addr_q == ADDR_CTRL && w_strb_q[0])
        ctrl_q <= ctrl_t'(w_data_q[CTRL_W-1:0]);
      else if (aw_addr_q == ADDR_TRIM_OFFSET)
        trim_q.offset <= merge16(trim_q.offset, w_data_q, w_strb_q);
      else if (aw_addr_q == ADDR_TRIM_GAIN)
        trim_q.gain <= merge16(trim_q.gain, w_data_q, w_strb_q);
      else if (aw_addr_q == ADDR_TRIM_TIMING)
        trim_q.timing <= merge16(trim_q.timing, w_data_q, w_strb_q);
      else if (aw_addr_q == ADDR_TRIM_TERM)
        trim_q.term <= merge16(trim_q.term, w_data_q, w_strb_q);
    end
  end

  assign stat = '{step: cal_step, eng_busy: eng_busy, map: map_q, bg_active: state_q == S_BG,
    fg_done: fg_done_q, fg_busy: state_q == S_FG};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == ADDR_CTRL)
        rdata_q <= {25'h0, ctrl_q};
      else if (s_axi_araddr == ADDR_STATUS)
        rdata_q <= {17'h0, stat};
      else if (s_axi_araddr == ADDR_TRIM_OFFSET)
        rdata_q <= {16'h0, trim_q.offset};
      else if (s_axi_araddr == ADDR_TRIM_GAIN)
        rdata_q <= {16'h0, trim_q.gain};
      else if (s_axi_araddr == ADDR_TRIM_TIMING)
        rdata_q <= {16'h0, trim_q.timing};
      else if (s_axi_araddr == ADDR_TRIM_TERM)
        rdata_q <= {16'h0, trim_q.term};
      else
        rdata_q <= 32'h0;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign sample_a = sample_a_q;
  assign sample_b = sample_b_q;
  assign core_online = online_q;
  assign core_on_input_b = in_b_q;
  assign trim = trim_q;
  // progress flag straight from the state flop
  assign cal_in_progress = state_q[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FG_MIDCODE: assert property ((state_q == S_FG) |=> sample_a == MID_CODE && sample_b == MID_CODE)
    else $error("samples not mid-code during foreground calibration");
  AST_FG_OFFLINE: assert property ((state_q == S_FG) |=> core_online == 3'h0)
    else $error("core online during foreground calibration");
  AST_POWERUP_FG: assert property ($rose(rst_n) |-> cal_in_progress ##1 eng_busy)
    else $error("no automatic calibration after reset");
  AST_TRIG_SEL: assert property ((state_q == S_IDLE && !bg_run && trig) |=> cal_in_progress ##1 eng_busy)
    else $error("selected trigger did not start calibration");
  AST_CORES_DISTINCT: assert property (map_q.slot_a != map_q.slot_b && map_q.spare != map_q.slot_a &&
    map_q.spare != map_q.slot_b && map_q.spare <= CORE_C && map_q.slot_a <= CORE_C && map_q.slot_b <= CORE_C)
    else $error("core map not a permutation of three cores");
  AST_PHASE: assert property ($past(rst_n) |-> phase_q != $past(phase_q))
    else $error("bank phase did not alternate");
  AST_DUAL_ROUTE: assert property (($past(rst_n) && !ctrl_q.single_ch && $stable(map_q) && $stable(ctrl_q)) |->
    !core_on_input_b[map_q.slot_a] && core_on_input_b[map_q.slot_b])
    else $error("dual channel routing wrong");
  AST_BG_SWAP: assert property ((state_q == S_BG && eng_done) |=>
    map_q.spare == ($past(next_b_q) ? $past(map_q.slot_b) : $past(map_q.slot_a)) && map_q.spare != $past(map_q.spare))
    else $error("spare core not swapped in");
  AST_BG_REPEAT: assert property ((state_q == S_BG && eng_done && bg_run) |-> ##[1:2] eng_busy)
    else $error("background rotation stopped");
  AST_NO_GAP: assert property ((state_q == S_BG && eng_busy) |-> cal_core != map_q.slot_a &&
    cal_core != map_q.slot_b)
    else $error("active slot core under calibration");
  AST_TRIM_RESET: assert property ($rose(rst_n) |-> trim == TRIM_DEFAULT)
    else $error("trim defaults not restored");
  AST_FG_END: assert property ((state_q == S_FG && eng_done && fg_core_q == CORE_C) |=>
    !cal_in_progress && fg_done_q)
    else $error("progress flag not cleared at completion");

  COV_FG_DONE: cover property (cal_in_progress ##1 !cal_in_progress);
  COV_BG_SWAP: cover property (state_q == S_BG && eng_done && next_b_q);
  COV_PIN_TRIG: cover property (state_q == S_IDLE && pin_rise && ctrl_q.cal_trigger_source_select);
endmodule // core_cal_ctrl
`default_nettype wire

// File: host_model.sv
`default_nettype none
module host_model import cal_pkg::*; (
  // clock
  input wire logic clk,
  // trigger pin
  output logic cal_pin_trigger,
  // bank data, top nibble names the bank, low byte moves
  output logic [NUM_BANKS-1:0][SAMPLE_W-1:0] bank_sample
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q = 8'h00;

  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_q + 8'h01;
  end

  // never zero, so a dropped sample reads as a gap
  always_comb
  begin
    for (int i = 0; i < NUM_BANKS; i++)
      bank_sample[i] = {4'(i + 1), cnt_q};
  end

  initial cal_pin_trigger = 1'b0;

  task automatic pulse_pin();
    @(posedge clk);
    cal_pin_trigger <= 1'b1;
    repeat (4) @(posedge clk);
    cal_pin_trigger <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb import cal_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
  logic clk, rst_n, cal_pin_trigger, cal_bank, cal_ref_en, cal_in_progress, bg_on, cip_q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, pa, pb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [NUM_BANKS-1:0][SAMPLE_W-1:0] bank_sample;
  logic [SAMPLE_W-1:0] sample_a, sample_b;
  logic [NUM_CORES-1:0] core_online, core_on_input_b;
  logic [4:0] steps;
  logic [1:0] banks;
  core_id_t cal_core;
  cal_step_t cal_step;
  trim_t trim;
  row_t rows[12];
  int fails, total_checks;

  core_cal_ctrl core_cal_ctrl_inst (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cal_pin_trigger(cal_pin_trigger),
    .bank_sample(bank_sample), .sample_a(sample_a), .sample_b(sample_b), .core_online(core_online),
    .core_on_input_b(core_on_input_b), .cal_core(cal_core), .cal_bank(cal_bank), .cal_step(cal_step),
    .cal_ref_en(cal_ref_en), .trim(trim), .cal_in_progress(cal_in_progress));
  host_model host_model_inst (.clk(clk), .cal_pin_trigger(cal_pin_trigger), .bank_sample(bank_sample));

  always #25 clk = ~clk;

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic hang(input string name);
    fails++;
    $display("Error %s expected done seen timeout", name);
    stop_test();
  endtask

  // valids held until taken at a rising edge; readiness settles mid-cycle
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] br);
    int n;
    logic ta, tw, got;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (got) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 200) hang("write");
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rr);
    int n;
    logic ta, got;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (got) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 200) hang("read");
  endtask

  function automatic logic [2:0] view(input int sel);
    return sel == 0 ? core_online : sel == 1 ? core_on_input_b : {2'b00, cal_in_progress};
  endfunction

  // a full background pass plus handover fits well inside 600 cycles
  task automatic wait_eq(input int sel, input logic [2:0] e);
    int n;
    for (n = 0; n < 600 && view(sel) !== e; n++)
      @(negedge clk);
    if (n == 600) hang("wait_eq");
  endtask

  always @(negedge clk)
  begin
    if (rst_n)
    begin
      if (cal_in_progress === 1'b1 && cip_q === 1'b1)
        check("fg_out", {sample_a, sample_b, core_online}, '0);
      if (bg_on)
        check("bg_gap", {sample_a == '0, sample_b == '0}, 2'b00);
      check("ref_en", cal_ref_en, cal_step !== ST_IDLE);
      steps = steps | cal_step;
      if (bg_on && cal_step != ST_IDLE)
      begin
        check("bg_cal_core", core_online[cal_core], 1'b0);
        banks[cal_bank] = 1'b1;
      end
    end
    cip_q = cal_in_progress;
  end

  initial
  begin
    {clk, rst_n, bg_on, cip_q, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, steps} = '0;
    s_axi_wstrb = 4'hf;
    rows = '{'{0, ADDR_TRIM_OFFSET, {16'h0, TRIM_DEFAULT.offset}, RESP_OKAY},
      '{0, ADDR_TRIM_GAIN, {16'h0, TRIM_DEFAULT.gain}, RESP_OKAY},
      '{0, ADDR_TRIM_TIMING, {16'h0, TRIM_DEFAULT.timing}, RESP_OKAY},
      '{0, ADDR_TRIM_TERM, {16'h0, TRIM_DEFAULT.term}, RESP_OKAY},
      '{0, ADDR_CTRL, 32'h0, RESP_OKAY}, '{0, ADDR_STATUS, 32'h492, RESP_OKAY},
      '{1, ADDR_TRIM_GAIN, 32'h1234, RESP_OKAY}, '{0, ADDR_TRIM_GAIN, 32'h1234, RESP_OKAY},
      '{1, 8'h18, 32'hffff, RESP_SLVERR}, '{0, 8'h18, 32'h0, RESP_SLVERR},
      '{1, ADDR_STATUS, 32'hffff, RESP_OKAY}, '{0, ADDR_STATUS, 32'h492, RESP_OKAY}};
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("rst_trim", trim, TRIM_DEFAULT);
    check("rst_out", {sample_a, sample_b, core_online, cal_step}, {27'h0, ST_IDLE});
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    check("fg_start", cal_in_progress, 1'b1);
    wait_eq(2, 3'h0);
    // outputs still show the last foreground cycle here
    @(negedge clk);
    check("fg_cores", {core_online, core_on_input_b}, 6'b011_010);
    pa = sample_a[11:8];
    pb = sample_b[11:8];
    repeat (4)
    begin
      @(negedge clk);
      check("alt_a", sample_a[11:8], pa == 4'h1 ? 4'h2 : 4'h1);
      check("alt_b", sample_b[11:8], pb == 4'h3 ? 4'h4 : 4'h3);
      pa = sample_a[11:8];
      pb = sample_b[11:8];
    end
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axi_wr(rows[i].a, rows[i].d, r);
      else
        axi_rd(rows[i].a, d, r);
      check("reg", {r, rows[i].wr ? 32'h0 : d}, {rows[i].r, rows[i].wr ? 32'h0 : rows[i].d});
    end
    check("trim_gain", trim.gain, 16'h1234);
    axi_wr(ADDR_CTRL, 32'h20, r);
    wait_eq(1, 3'b000);
    axi_wr(ADDR_CTRL, 32'h60, r);
    wait_eq(1, 3'b011);
    axi_wr(ADDR_CTRL, 32'h00, r);
    wait_eq(1, 3'b010);
    axi_wr(ADDR_CTRL, 32'h02, r);
    wait_eq(2, 3'h1);
    wait_eq(2, 3'h0);
    axi_wr(ADDR_CTRL, 32'h01, r);
    host_model_inst.pulse_pin();
    wait_eq(2, 3'h1);
    wait_eq(2, 3'h0);
    axi_wr(ADDR_CTRL, 32'h00, r);
    host_model_inst.pulse_pin();
    repeat (10) @(negedge clk);
    check("pin_ignored", cal_in_progress, 1'b0);
    // enable, software source, trigger held high
    axi_wr(ADDR_CTRL, 32'h06, r);
    bg_on = 1'b1;
    steps = '0;
    banks = '0;
    wait_eq(0, 3'b110);
    check("bg_no_fg", cal_in_progress, 1'b0);
    wait_eq(0, 3'b101);
    check("steps", steps & 5'b01110, 5'b01110);
    check("banks", banks, 2'b11);
    bg_on = 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    check("rerst", trim, TRIM_DEFAULT);
    check("rerst_online", core_online, 3'b000);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_eq(2, 3'h1);
    wait_eq(2, 3'h0);
    wait_eq(0, 3'b011);
    stop_test();
  end
endmodule // tb
`default_nettype wire
